// *** hw/stk_pkg.sv ***
// Purpose: Shared constants for the stack, return and subtract executor
// Assumes: One 40 MHz core clock, four phases per instruction cycle
// Notes:   Offsets are byte addresses on the AHB-Lite register bus
package stk_pkg;
  // ----------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------
  localparam logic [7:0] A_CTRL = 8'h00;
  localparam logic [7:0] A_WREG = 8'h04;
  localparam logic [7:0] A_FLAGS = 8'h08;
  localparam logic [7:0] A_BANK = 8'h0c;
  localparam logic [7:0] A_SHADOW = 8'h10;
  localparam logic [7:0] A_PC = 8'h14;
  localparam logic [7:0] A_HEAD = 8'h18;
  localparam logic [7:0] A_IRQ = 8'h1c;
  localparam logic [7:0] A_LATCH = 8'h20;
  localparam int CTRL_LOW_BIT = 16;
  // ----------------------------------------------------------------
  // Sizes and reset values
  // ----------------------------------------------------------------
  localparam int PC_W = 21;
  localparam int SP_W = 5;
  localparam logic [SP_W-1:0] STK_DEPTH = 5'h1f;
  localparam logic [PC_W-1:0] PC_STEP = 21'h000002;
  localparam logic [PC_W-1:0] PC_RST = 21'h000000;
  localparam logic [7:0] W_RST = 8'h00;
  localparam logic [4:0] FLAGS_RST = 5'h00;
  localparam logic [3:0] BANK_RST = 4'h0;
  // Flag positions: carry, digit carry, zero, overflow, negative
  localparam int F_C = 0;
  localparam int F_DC = 1;
  localparam int F_Z = 2;
  localparam int F_OV = 3;
  localparam int F_N = 4;
  // ----------------------------------------------------------------
  // Opcodes and phase timing
  // ----------------------------------------------------------------
  localparam logic [15:0] OP_POP = 16'h0006;
  localparam logic [15:0] OP_PUSH = 16'h0005;
  localparam logic [14:0] OP_INTERRUPT_RETURN_OP_HI = 15'h0008;
  localparam logic [7:0] OP_LITERAL_MINUS_ACC_OP_HI = 8'h08;
  localparam logic [1:0] Q_PUSH = 2'h1;
  localparam logic [1:0] Q_POP = 2'h2;
  localparam logic [1:0] Q_LAST = 2'h3;
  typedef enum logic [1:0] {EX_IDLE, EX_RUN, EX_NOP} exec_state_t;
endpackage

// *** hw/stack_return_subtract_exec.sv ***
// Purpose: Executes discard, push, interrupt return and literal subtract
// Assumes: Opcodes arrive by a bus write to the control register
// Notes:   Core updates win over a bus write to the same register
// Behaviour
// [RQ1] A discard removes the top stack entry and leaves flags alone.
// [RQ2] After a discard the head shows the entry pushed before it.
// [RQ3] A push writes PC plus two as new head in phase two.
// [RQ4] Interrupt return pops the stack into PC and sets one enable.
// [RQ5] With restore set, shadow values reload W, flags and bank.
// [RQ6] With restore clear, W, flags and bank stay untouched.
// [RQ7] Interrupt return takes two cycles, acting in phase four of the first.
// [RQ8] Interrupt return leaves both PC latch registers unchanged.
// [RQ9] Literal subtract puts literal minus W in W with flags, in one cycle.
// [RQ10] Carry means no borrow, zero marks zero, negative copies bit seven.
//
// Added by the designer: the AHB-Lite register port and the address map.
`timescale 1ns/1ps
module stack_return_subtract_exec
  import stk_pkg::*;
(
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  output logic high_prio_global_irq_enable,
  output logic low_prio_global_irq_enable
);
  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  logic [PC_W-1:0] stk [0:30];
  logic [SP_W-1:0] sp_r, sp_nxt;
  logic [PC_W-1:0] pc_r, pc_nxt;
  logic [7:0] w_r, w_nxt;
  logic [4:0] fl_r, fl_nxt;
  logic [3:0] bank_select_reg, bank_nxt;
  logic [7:0] shadow_accumulator, ws_nxt;
  logic [4:0] shadow_flags, sf_nxt;
  logic [3:0] shadow_bank_select, sb_nxt;
  logic [4:0] pc_upper_latch, plu_nxt;
  logic [7:0] pc_high_latch, plh_nxt;
  logic gie_hi_r, gie_hi_nxt, gie_lo_r, gie_lo_nxt;
  exec_state_t st_r, st_nxt;
  logic [1:0] q_r, q_nxt;
  logic [15:0] op_r, op_nxt;
  logic lowsel_r, lowsel_nxt, pend_r, pend_nxt;
  logic wr_r, wr_nxt, rd_r, rd_nxt, rdy_r, rdy_nxt;
  logic [7:0] adr_r, adr_nxt;
  logic [31:0] rdat_r, rdat_nxt;
  logic st_we;
  logic [SP_W-1:0] st_idx;
  logic [PC_W-1:0] stack_head, prev_entry;
  logic is_pop, is_push, is_ret, is_sub, run;
  logic [8:0] diff;
  logic [4:0] nib;

  // Head is zero when the stack is empty, so a stray return lands at 0
  assign stack_head = (sp_r == 5'h00) ? PC_RST : stk[sp_r - 5'h01];
  assign prev_entry = (sp_r > 5'h01) ? stk[sp_r - 5'h02] : PC_RST;
  assign run = (st_r == EX_RUN);
  assign is_pop = run && (op_r == OP_POP);
  assign is_push = run && (op_r == OP_PUSH);
  assign is_ret = run && (op_r[15:1] == OP_INTERRUPT_RETURN_OP_HI);
  assign is_sub = run && (op_r[15:8] == OP_LITERAL_MINUS_ACC_OP_HI);
  // Literal plus inverted W plus one; bit 8 is the no-borrow carry
  assign diff = {1'b0, op_r[7:0]} + {1'b0, ~w_r} + 9'h001;
  assign nib = {1'b0, op_r[3:0]} + {1'b0, ~w_r[3:0]} + 5'h01;

  // ----------------------------------------------------------------
  // Bus read mux
  // ----------------------------------------------------------------
  function automatic logic [31:0] rd_word(input logic [7:0] a);
    logic [31:0] d;
    d = 32'h0000_0000;
    if (a == A_CTRL)
      d = {14'h0000, pend_r || (st_r != EX_IDLE), lowsel_r, op_r};
    else if (a == A_WREG)
      d = {24'h000000, w_r};
    else if (a == A_FLAGS)
      d = {27'h0000000, fl_r};
    else if (a == A_BANK)
      d = {28'h0000000, bank_select_reg};
    else if (a == A_SHADOW)
      d = {12'h000, shadow_bank_select, 3'h0, shadow_flags,
           shadow_accumulator};
    else if (a == A_PC)
      d = {11'h000, pc_r};
    else if (a == A_HEAD)
      d = {3'h0, sp_r, 3'h0, stack_head};
    else if (a == A_IRQ)
      d = {30'h00000000, gie_lo_r, gie_hi_r};
    else if (a == A_LATCH)
      d = {16'h0000, pc_high_latch, 3'h0, pc_upper_latch};
    return d;
  endfunction

  // ----------------------------------------------------------------
  // Next state: bus slave, sequencer and execution
  // ----------------------------------------------------------------
  // Reads take one wait state so they always see the latest write
  always_comb
  begin
    sp_nxt = sp_r;
    pc_nxt = pc_r;
    w_nxt = w_r;
    fl_nxt = fl_r;
    bank_nxt = bank_select_reg;
    ws_nxt = shadow_accumulator;
    sf_nxt = shadow_flags;
    sb_nxt = shadow_bank_select;
    plu_nxt = pc_upper_latch;
    plh_nxt = pc_high_latch;
    gie_hi_nxt = gie_hi_r;
    gie_lo_nxt = gie_lo_r;
    st_nxt = st_r;
    q_nxt = q_r + 2'h1;
    op_nxt = op_r;
    lowsel_nxt = lowsel_r;
    pend_nxt = pend_r;
    st_we = 1'b0;
    st_idx = sp_r;
    adr_nxt = adr_r;
    rdat_nxt = rdat_r;
    rdy_nxt = 1'b1;
    wr_nxt = 1'b0;
    rd_nxt = 1'b0;
    if (rd_r)
      rdat_nxt = rd_word(adr_r);
    if (hsel && htrans[1] && hready)
    begin
      adr_nxt = haddr[7:0];
      wr_nxt = hwrite;
      rd_nxt = !hwrite;
      rdy_nxt = hwrite;
    end
    // Write data phase; an opcode is refused while one is in flight
    if (wr_r)
    begin
      if (adr_r == A_CTRL)
      begin
        if (!pend_r && (st_r == EX_IDLE))
        begin
          op_nxt = hwdata[15:0];
          lowsel_nxt = hwdata[CTRL_LOW_BIT];
          pend_nxt = 1'b1;
        end
      end
      else if (adr_r == A_WREG)
        w_nxt = hwdata[7:0];
      else if (adr_r == A_FLAGS)
        fl_nxt = hwdata[4:0];
      else if (adr_r == A_BANK)
        bank_nxt = hwdata[3:0];
      else if (adr_r == A_SHADOW)
      begin
        ws_nxt = hwdata[7:0];
        sf_nxt = hwdata[12:8];
        sb_nxt = hwdata[19:16];
      end
      else if (adr_r == A_PC)
        pc_nxt = hwdata[PC_W-1:0];
      else if (adr_r == A_IRQ)
      begin
        gie_hi_nxt = hwdata[0];
        gie_lo_nxt = hwdata[1];
      end
      else if (adr_r == A_LATCH)
      begin
        plu_nxt = hwdata[4:0];
        plh_nxt = hwdata[15:8];
      end
    end
    // A push onto a full stack is dropped rather than wrapping
    if (is_push && (q_r == Q_PUSH) && (sp_r < STK_DEPTH))
    begin
      st_we = 1'b1; // RQ3
      sp_nxt = sp_r + 5'h01; // RQ3
    end
    // Discard in phase three; flags are not touched
    if (is_pop && (q_r == Q_POP) && (sp_r != 5'h00))
      sp_nxt = sp_r - 5'h01; // RQ1 RQ2
    if (q_r == Q_LAST)
    begin
      if (is_ret)
      begin
        pc_nxt = stack_head; // RQ4 RQ8
        if (sp_r != 5'h00)
          sp_nxt = sp_r - 5'h01; // RQ4
        if (lowsel_r)
          gie_lo_nxt = 1'b1; // RQ4
        else
          gie_hi_nxt = 1'b1; // RQ4
        if (op_r[0]) // RQ5 RQ6
        begin
          w_nxt = shadow_accumulator; // RQ5
          fl_nxt = shadow_flags; // RQ5
          bank_nxt = shadow_bank_select; // RQ5
        end
      end
      else if (run)
        pc_nxt = pc_r + PC_STEP;
      if (is_sub)
      begin
        w_nxt = diff[7:0]; // RQ9
        fl_nxt[F_C] = diff[8]; // RQ10
        fl_nxt[F_DC] = nib[4];
        fl_nxt[F_Z] = (diff[7:0] == 8'h00); // RQ10
        fl_nxt[F_OV] = (op_r[7] != w_r[7]) && (diff[7] != op_r[7]);
        fl_nxt[F_N] = diff[7]; // RQ10
      end
      // Sequencer moves only on cycle boundaries
      case (st_r)
        EX_IDLE:
          if (pend_r)
          begin
            st_nxt = EX_RUN;
            pend_nxt = 1'b0;
          end
        EX_RUN:
          st_nxt = is_ret ? EX_NOP : EX_IDLE; // RQ7
        EX_NOP:
          st_nxt = EX_IDLE; // RQ7
        default:
          st_nxt = EX_IDLE;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      sp_r <= 5'h00;
      pc_r <= PC_RST;
      w_r <= W_RST;
      fl_r <= FLAGS_RST;
      bank_select_reg <= BANK_RST;
      shadow_accumulator <= W_RST;
      shadow_flags <= FLAGS_RST;
      shadow_bank_select <= BANK_RST;
      pc_upper_latch <= 5'h00;
      pc_high_latch <= 8'h00;
      gie_hi_r <= 1'b0;
      gie_lo_r <= 1'b0;
      st_r <= EX_IDLE;
      q_r <= 2'h0;
      op_r <= 16'h0000;
      lowsel_r <= 1'b0;
      pend_r <= 1'b0;
      wr_r <= 1'b0;
      rd_r <= 1'b0;
      rdy_r <= 1'b1;
      adr_r <= 8'h00;
      rdat_r <= 32'h0000_0000;
    end
    else
    begin
      sp_r <= sp_nxt;
      pc_r <= pc_nxt;
      w_r <= w_nxt;
      fl_r <= fl_nxt;
      bank_select_reg <= bank_nxt;
      shadow_accumulator <= ws_nxt;
      shadow_flags <= sf_nxt;
      shadow_bank_select <= sb_nxt;
      pc_upper_latch <= plu_nxt;
      pc_high_latch <= plh_nxt;
      gie_hi_r <= gie_hi_nxt;
      gie_lo_r <= gie_lo_nxt;
      st_r <= st_nxt;
      q_r <= q_nxt;
      op_r <= op_nxt;
      lowsel_r <= lowsel_nxt;
      pend_r <= pend_nxt;
      wr_r <= wr_nxt;
      rd_r <= rd_nxt;
      rdy_r <= rdy_nxt;
      adr_r <= adr_nxt;
      rdat_r <= rdat_nxt;
    end
  end

  // Stack array has no reset; the pointer alone defines what is valid
  always_ff @(posedge hclk)
  begin
    if (st_we)
      stk[st_idx] <= pc_r + PC_STEP; // RQ3
  end

  assign hreadyout = rdy_r;
  assign hrdata = rdat_r;
  assign hresp = 1'b0 & rdy_r;
  assign high_prio_global_irq_enable = gie_hi_r;
  assign low_prio_global_irq_enable = gie_lo_r;

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  a_pop_drops_head: assert property ( // RQ1
    is_pop && q_r == Q_POP && sp_r != 5'h00 && !wr_r
    |=> sp_r == $past(sp_r) - 5'h01 && fl_r == $past(fl_r))
    else $error("discard did not drop head");
  a_pop_older_head: assert property ( // RQ2
    is_pop && q_r == Q_POP && sp_r != 5'h00
    |=> stack_head == $past(prev_entry))
    else $error("discard exposed wrong entry");
  a_push_pc_two: assert property ( // RQ3
    is_push && q_r == Q_PUSH && sp_r < STK_DEPTH
    |=> stack_head == $past(pc_r) + PC_STEP)
    else $error("push head not pc plus two");
  a_ret_pc_gie: assert property ( // RQ4
    is_ret && q_r == Q_LAST
    |=> pc_r == $past(stack_head)
        && ($past(lowsel_r) ? gie_lo_r : gie_hi_r))
    else $error("return pop or enable wrong");
  a_ret_restore: assert property ( // RQ5
    is_ret && q_r == Q_LAST && op_r[0]
    |=> w_r == $past(shadow_accumulator) && fl_r == $past(shadow_flags)
        && bank_select_reg == $past(shadow_bank_select))
    else $error("shadow restore missing");
  a_ret_no_restore: assert property ( // RQ6
    is_ret && q_r == Q_LAST && !op_r[0] && !wr_r
    |=> $stable(w_r) && $stable(fl_r) && $stable(bank_select_reg))
    else $error("registers changed without restore");
  a_ret_two_cycles: assert property ( // RQ7
    is_ret && q_r == Q_LAST |=> (st_r == EX_NOP) [*4] ##1 st_r == EX_IDLE)
    else $error("return not two cycles");
  a_ret_latch_keep: assert property ( // RQ8
    is_ret && q_r == Q_LAST && !wr_r
    |=> $stable(pc_upper_latch) && $stable(pc_high_latch))
    else $error("pc latches changed");
  a_sub_result: assert property ( // RQ9
    is_sub && q_r == Q_LAST
    |=> w_r == $past(op_r[7:0]) - $past(w_r) && st_r == EX_IDLE)
    else $error("subtract result wrong");
  a_sub_flags: assert property ( // RQ10
    is_sub && q_r == Q_LAST
    |=> fl_r[F_N] == w_r[7] && fl_r[F_Z] == (w_r == 8'h00)
        && fl_r[F_C] == ($past(op_r[7:0]) >= $past(w_r)))
    else $error("subtract flags wrong");

  c_push: cover property (is_push && q_r == Q_PUSH);
  c_pop: cover property (is_pop && q_r == Q_POP && sp_r > 5'h01);
  c_ret_restore: cover property (is_ret && q_r == Q_LAST && op_r[0]);
  c_sub_zero: cover property (is_sub && q_r == Q_LAST && diff[7:0] == 8'h00);
endmodule // stack_return_subtract_exec

// *** dv/test_stack_return_subtract_exec.sv ***
// Purpose: Self-checking bench for the stack, return and subtract executor
// Assumes: One AHB-Lite master, hready looped back from hreadyout
// Notes:   Expected values come from bench functions, never the design
`timescale 1ns/1ps
module test_stack_return_subtract_exec;
  import stk_pkg::*;
  `define CHK(n, e, g) begin checked++; if ((g) !== (e)) begin \
    miscompares++; $display("BAD %s exp %h got %h", n, e, g); end end
  // ----------------------------------------------------------------
  // Signals
  // ----------------------------------------------------------------
  logic hclk, hresetn, hsel, hwrite, hreadyout, irq_hi, irq_lo, hresp;
  logic [31:0] haddr, hwdata, hrdata, rd;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic [20:0] p;
  logic [7:0] w, k;
  logic [4:0] f;
  logic [3:0] b;
  logic [12:0] e;
  int miscompares, checked;

  // Single slave, so its hreadyout is the bus ready
  stack_return_subtract_exec u_dut (.hclk(hclk), .hresetn(hresetn),
    .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
    .high_prio_global_irq_enable(irq_hi),
    .low_prio_global_irq_enable(irq_lo));

  // 40 MHz clock
  initial
  begin
    hclk = 1'b0;
    forever #12.5 hclk = ~hclk;
  end

  // ----------------------------------------------------------------
  // Reference and bus helpers
  // ----------------------------------------------------------------
  // Literal minus W with flags; carry means no borrow
  function automatic logic [12:0] sub_exp(input logic [7:0] wv,
                                          input logic [7:0] kv);
    logic [8:0] d;
    logic [4:0] fl;
    d = {1'b0, kv} - {1'b0, wv};
    fl[F_C] = ~d[8];
    fl[F_DC] = (kv[3:0] >= wv[3:0]);
    fl[F_Z] = (d[7:0] == 8'h00);
    fl[F_OV] = (kv[7] != wv[7]) && (d[7] != kv[7]);
    fl[F_N] = d[7];
    return {fl, d[7:0]};
  endfunction

  // One transfer; entered just after a rising edge, waits on hready
  task automatic bus(input logic wr_en, input logic [7:0] a,
                     input logic [31:0] wd, output logic [31:0] rdv);
    hsel <= 1'b1;
    haddr <= {24'h0, a};
    hwrite <= wr_en;
    htrans <= 2'h2;
    @(posedge hclk);
    while (hreadyout !== 1'b1) @(posedge hclk);
    htrans <= 2'h0;
    hwdata <= wd;
    @(posedge hclk);
    while (hreadyout !== 1'b1) @(posedge hclk);
    rdv = hrdata;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    bus(1'b1, a, d, rd);
  endtask

  task automatic chk_reg(input string n, input logic [7:0] a,
                         input logic [31:0] ex);
    bus(1'b0, a, 32'h0, rd);
    `CHK(n, ex, rd);
  endtask

  // Issue one opcode, then poll busy with a bounded count
  task automatic exec(input logic [31:0] c);
    int n;
    wr(A_CTRL, c);
    n = 0;
    do
    begin
      bus(1'b0, A_CTRL, 32'h0, rd);
      n++;
    end
    while (rd[17] !== 1'b0 && n < 40);
    if (n >= 40)
    begin
      miscompares++;
      $display("BAD busy exp 0 got 1");
    end
  endtask

  task automatic wrap_up;
    if (miscompares == 0 && checked > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  // Watchdog: whole run is a few hundred cycles
  initial
  begin
    repeat (20000) @(posedge hclk);
    miscompares++;
    wrap_up;
  end

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial
  begin
    hsel = 1'b0;
    haddr = 32'h0;
    htrans = 2'h0;
    hwrite = 1'b0;
    hsize = 3'h2;
    hwdata = 32'h0;
    hresetn = 1'b0;
    miscompares = 0;
    checked = 0;
    void'($urandom(32'hfb20));
    repeat (6) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    chk_reg("irq rst", A_IRQ, 32'h0);
    chk_reg("unmapped", 8'h3c, 32'h0);
    // Two pushes then a discard; flags must survive the discard
    p = 21'($urandom()) & 21'h0ffff0;
    wr(A_PC, {11'h0, p});
    exec(32'(OP_PUSH));
    chk_reg("head1", A_HEAD, {8'h01, 3'h0, p + PC_STEP});
    exec(32'(OP_PUSH));
    chk_reg("head2", A_HEAD, {8'h02, 3'h0, p + 21'h4});
    f = 5'($urandom());
    wr(A_FLAGS, {27'h0, f});
    exec(32'(OP_POP));
    chk_reg("head pop", A_HEAD, {8'h01, 3'h0, p + 21'h2});
    chk_reg("flags pop", A_FLAGS, {27'h0, f});
    chk_reg("pc pop", A_PC, {11'h0, p + 21'h6});
    // High-priority return with shadow restore
    w = 8'($urandom());
    f = 5'($urandom());
    b = 4'($urandom());
    wr(A_SHADOW, {12'h0, b, 3'h0, f, w});
    wr(A_WREG, {24'h0, ~w});
    wr(A_FLAGS, {27'h0, ~f});
    wr(A_BANK, {28'h0, ~b});
    wr(A_LATCH, 32'h0000_5a13);
    exec(32'h0000_0011);
    chk_reg("pc ret1", A_PC, {11'h0, p + 21'h2});
    chk_reg("w ret1", A_WREG, {24'h0, w});
    chk_reg("flags ret1", A_FLAGS, {27'h0, f});
    chk_reg("bank ret1", A_BANK, {28'h0, b});
    chk_reg("irq ret1", A_IRQ, 32'h1);
    chk_reg("latch ret1", A_LATCH, 32'h0000_5a13);
    `CHK("hi pin", 32'h1, 32'(irq_hi));
    // Low-priority return, no restore: W stays as written
    exec(32'(OP_PUSH));
    k = 8'($urandom());
    wr(A_WREG, {24'h0, k});
    exec(32'h0001_0010);
    chk_reg("pc ret0", A_PC, {11'h0, p + 21'h4});
    chk_reg("w ret0", A_WREG, {24'h0, k});
    chk_reg("flags ret0", A_FLAGS, {27'h0, f});
    chk_reg("bank ret0", A_BANK, {28'h0, b});
    chk_reg("irq ret0", A_IRQ, 32'h3);
    `CHK("lo pin", 32'h1, 32'(irq_lo));
    // Unknown opcode only steps PC; an opcode written while busy is lost
    wr(A_CTRL, 32'h0000_0000);
    exec(32'(OP_PUSH));
    chk_reg("pc unknown", A_PC, {11'h0, p + 21'h6});
    chk_reg("head refused", A_HEAD, 32'h0);
    chk_reg("ctrl refused", A_CTRL, 32'h0);
    `CHK("resp", 32'h0, 32'(hresp));
    // Subtract: positive, zero, negative, overflow, then random
    for (int i = 0; i < 16; i++)
    begin
      w = (i < 3) ? 8'(i + 1) : 8'($urandom());
      k = (i < 3) ? 8'h02 : 8'($urandom());
      if (i == 3)
      begin
        w = 8'h80;
        k = 8'h01;
      end
      e = sub_exp(w, k);
      wr(A_WREG, {24'h0, w});
      exec({16'h0, OP_LITERAL_MINUS_ACC_OP_HI, k});
      chk_reg("w sub", A_WREG, {24'h0, e[7:0]});
      chk_reg("flags sub", A_FLAGS, {27'h0, e[12:8]});
    end
    wrap_up;
  end
endmodule // test_stack_return_subtract_exec
